/* hw/ldexec.sv */
`timescale 1ns/1ps
module ldexec (
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire ldexec_pkg::instr_t  instr,
    input  wire logic [15:0]         rf_rd_data,
    output ldexec_pkg::rf_req_t      rf_req,
    output ldexec_pkg::mem_req_t     mem_req,
    output logic                     busy,
    output logic                     done,
    output logic                     illegal
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        ldexec_pkg::state_t   st;
        logic [4:0]           cnt;
        logic [7:0]           opc;
        logic [7:0]           dst;
        logic [7:0]           src;
        logic [7:0]           imm_low;
        logic [15:0]          ptr;
        ldexec_pkg::rf_req_t  rf;
        ldexec_pkg::mem_req_t mem;
        logic                 busy;
        logic                 done;
        logic                 illegal;
    } core_t;

    core_t       cur;
    core_t       next_cur;
    logic [7:0]  step_high;
    logic [7:0]  step_low;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] pair_base(input logic [7:0] fld);
        pair_base = {fld[7:1], 1'b0};
    endfunction : pair_base

    function automatic logic is_store(input logic [7:0] op);
        is_store = (op == ldexec_pkg::OPC_PREDEC) ||
                   (op == ldexec_pkg::OPC_PREINC);
    endfunction : is_store

    function automatic logic is_word(input logic [7:0] op);
        is_word = (op == ldexec_pkg::OPC_WORD_RR) ||
                  (op == ldexec_pkg::OPC_WORD_IR) ||
                  (op == ldexec_pkg::OPC_WORD_IML);
    endfunction : is_word

    // ------------------------------------------------------------
    // Pointer arithmetic
    // ------------------------------------------------------------
    ptr_step u_step (
        .high_in  (rf_rd_data[15:8]),
        .low_in   (rf_rd_data[7:0]),
        .dec      (cur.opc == ldexec_pkg::OPC_PREDEC),
        .high_out (step_high),
        .low_out  (step_low)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        next_cur.rf.rd_en  = 1'b0;
        next_cur.rf.wr_en  = 1'b0;
        next_cur.rf.wr_word = 1'b0;
        next_cur.mem.wr_en = 1'b0;
        next_cur.done      = 1'b0;
        next_cur.illegal   = 1'b0;
        if (cur.st != ldexec_pkg::ST_IDLE) begin
            next_cur.cnt = cur.cnt - 5'h01;
        end
        case (cur.st)
            ldexec_pkg::ST_IDLE: begin
                if (instr.valid) begin
                    next_cur.opc     = instr.opcode;
                    next_cur.dst     = instr.dst;
                    next_cur.src     = instr.src;
                    next_cur.imm_low = instr.imm_low;
                    if (is_store(instr.opcode)) begin
                        next_cur.busy = 1'b1;
                        next_cur.cnt  = ldexec_pkg::CYC_STORE - 5'h01;
                        next_cur.rf.rd_en   = 1'b1;
                        next_cur.rf.rd_addr = pair_base(instr.dst);
                        next_cur.st   = ldexec_pkg::ST_RD_PTR;
                    end else if (is_word(instr.opcode)) begin
                        next_cur.busy = 1'b1;
                        next_cur.cnt  = ldexec_pkg::CYC_WORD - 5'h01;
                        next_cur.st   = ldexec_pkg::ST_WORD_RD;
                        if (instr.opcode != ldexec_pkg::OPC_WORD_IML) begin
                            next_cur.rf.rd_en   = 1'b1;
                            next_cur.rf.rd_addr = instr.src;
                        end
                    end else begin
                        next_cur.illegal = 1'b1;
                    end
                end
            end
            ldexec_pkg::ST_RD_PTR: begin
                // Pointer updated before any memory access
                next_cur.ptr = {step_high, step_low};
                next_cur.rf.rd_en   = 1'b1;
                next_cur.rf.rd_addr = cur.src;
                next_cur.st = ldexec_pkg::ST_RD_SRC;
            end
            ldexec_pkg::ST_RD_SRC: begin
                next_cur.mem.wr_en = 1'b1;
                next_cur.mem.addr  = cur.ptr;
                // Source register sits in the high byte of the read
                next_cur.mem.data  = rf_rd_data[15:8];
                next_cur.mem.prog_space = ~cur.dst[0];
                next_cur.st = ldexec_pkg::ST_MEM_WR;
            end
            ldexec_pkg::ST_MEM_WR: begin
                // Pair written back for both spaces; source untouched
                next_cur.rf.wr_en   = 1'b1;
                next_cur.rf.wr_word = 1'b1;
                next_cur.rf.wr_addr = pair_base(cur.dst);
                next_cur.rf.wr_data = cur.ptr;
                next_cur.st = ldexec_pkg::ST_WAIT;
            end
            ldexec_pkg::ST_WORD_RD: begin
                next_cur.st = ldexec_pkg::ST_WORD_WR;
                if (cur.opc == ldexec_pkg::OPC_WORD_IR) begin
                    next_cur.rf.rd_en   = 1'b1;
                    // Address register sits in the high byte
                    next_cur.rf.rd_addr = rf_rd_data[15:8];
                    next_cur.st = ldexec_pkg::ST_WR_PTR;
                end else begin
                    next_cur.rf.wr_en   = 1'b1;
                    next_cur.rf.wr_word = 1'b1;
                    next_cur.rf.wr_addr = cur.dst;
                    next_cur.rf.wr_data =
                        (cur.opc == ldexec_pkg::OPC_WORD_IML)
                        ? {cur.src, cur.imm_low} : rf_rd_data;
                    next_cur.st = ldexec_pkg::ST_WAIT;
                end
            end
            ldexec_pkg::ST_WR_PTR: begin
                // Indirect word arrives one cycle after its address
                next_cur.rf.wr_en   = 1'b1;
                next_cur.rf.wr_word = 1'b1;
                next_cur.rf.wr_addr = cur.dst;
                next_cur.rf.wr_data = rf_rd_data;
                next_cur.st = ldexec_pkg::ST_WAIT;
            end
            ldexec_pkg::ST_WORD_WR: begin
                next_cur.st = ldexec_pkg::ST_WAIT;
            end
            ldexec_pkg::ST_WAIT: begin
                // Pad to the fixed instruction length
                if (cur.cnt == 5'h01) begin
                    next_cur.busy = 1'b0;
                    next_cur.done = 1'b1;
                    next_cur.st   = ldexec_pkg::ST_IDLE;
                end
            end
            default: begin
                next_cur.st = ldexec_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur <= '0;
            cur.st <= ldexec_pkg::ST_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // No flag port: condition flags never touched
    assign rf_req  = cur.rf;
    assign mem_req = cur.mem;
    assign busy    = cur.busy;
    assign done    = cur.done;
    assign illegal = cur.illegal;
endmodule : ldexec

/* hw/ldexec_pkg.sv */
// Notes on behaviour
// - Opcode F2 is predecrement store, 14 cycles
// - Pointer pair decremented first, then used
// - Source byte written at the updated address
// - Opcode F3 increments pointer, stores, 14 cycles
// - Each store targets program or external space
// - Even pair field selects program memory
// - Pair is 16 bits, even byte high
// - No condition flag is ever changed
// - Source operand never written
// - Word load copies 16 bits at once
// - Word load forms C4/C5/C6, 8 cycles each
// - High byte to register dst, low byte to dst + 1
package ldexec_pkg;

    // ------------------------------------------------------------
    // Opcodes and timing
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_PREDEC    = 8'hF2;
    localparam logic [7:0] OPC_PREINC    = 8'hF3;
    localparam logic [7:0] OPC_WORD_RR   = 8'hC4;
    localparam logic [7:0] OPC_WORD_IR   = 8'hC5;
    localparam logic [7:0] OPC_WORD_IML  = 8'hC6;
    localparam logic [4:0] CYC_STORE     = 5'h0E;
    localparam logic [4:0] CYC_WORD      = 5'h08;
    localparam logic [7:0] RESET_BYTE    = 8'h00;
    localparam logic [15:0] RESET_WORD   = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_PTR,
        ST_RD_SRC,
        ST_MEM_WR,
        ST_WR_PTR,
        ST_WORD_RD,
        ST_WORD_WR,
        ST_WAIT
    } state_t;

    // Decoded instruction from the front end
    typedef struct packed {
        logic       valid;
        logic [7:0] opcode;
        logic [7:0] dst;
        logic [7:0] src;
        logic [7:0] imm_low;
    } instr_t;

    // Register file port
    typedef struct packed {
        logic        rd_en;
        logic [7:0]  rd_addr;
        logic        wr_en;
        logic [7:0]  wr_addr;
        logic [15:0] wr_data;
        logic        wr_word;
    } rf_req_t;

    // Memory bus request
    typedef struct packed {
        logic        wr_en;
        logic        prog_space;
        logic [15:0] addr;
        logic [7:0]  data;
    } mem_req_t;

endpackage : ldexec_pkg

/* hw/ptr_step.sv */
`timescale 1ns/1ps
module ptr_step (
    input  wire logic [7:0]  high_in,
    input  wire logic [7:0]  low_in,
    input  wire logic        dec,
    output logic      [7:0]  high_out,
    output logic      [7:0]  low_out
);
    logic [15:0] sum;

    // Carry and borrow ride across both bytes
    always_comb begin
        sum = dec ? ({high_in, low_in} - 16'h0001)
                  : ({high_in, low_in} + 16'h0001);
        high_out = sum[15:8];
        low_out  = sum[7:0];
    end
endmodule : ptr_step

/* verif/ldexec_checker.sv */
`timescale 1ns/1ps
module ldexec_checker (
    input wire logic                 clk,
    input wire logic                 resetn,
    input wire ldexec_pkg::instr_t   instr,
    input wire logic [15:0]          rf_rd_data,
    input wire ldexec_pkg::rf_req_t  rf_req,
    input wire ldexec_pkg::mem_req_t mem_req,
    input wire logic                 busy,
    input wire logic                 done,
    input wire logic                 illegal
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic take;
    logic dec;
    logic st;
    assign take = instr.valid && !busy;
    assign dec  = take && instr.opcode == ldexec_pkg::OPC_PREDEC;
    assign st   = dec || (take && instr.opcode == ldexec_pkg::OPC_PREINC);
    chk_store_time: assert property (st |-> ##14 done)
        else $error("store done late");
    chk_word_time: assert property (take && instr.opcode inside
        {8'hC4, 8'hC5, 8'hC6} |-> ##8 done) else $error("word done late");
    chk_one_write: assert property (st |-> !mem_req.wr_en [*3]
        ##1 mem_req.wr_en ##1 !mem_req.wr_en [*8]) else $error("write count");
    chk_dec_addr: assert property (dec |-> ##3
        mem_req.addr == $past(rf_rd_data, 2) - 16'h0001)
        else $error("dec addr");
    chk_inc_addr: assert property (st && !dec |-> ##3
        mem_req.addr == $past(rf_rd_data, 2) + 16'h0001)
        else $error("inc addr");
    chk_space_sel: assert property (st |-> ##3
        mem_req.prog_space == !$past(instr.dst[0], 3)) else $error("space");
    chk_ptr_back: assert property (st |-> ##4 rf_req.wr_en &&
        rf_req.wr_data == $past(mem_req.addr)) else $error("pointer write");
    chk_imm_word: assert property (take && instr.opcode == 8'hC6
        |-> ##2 rf_req.wr_en && rf_req.wr_data ==
        {$past(instr.src, 2), $past(instr.imm_low, 2)}) else $error("imm");
    chk_pair_addr: assert property (st |-> ##4
        rf_req.wr_addr == {$past(instr.dst[7:1], 4), 1'b0})
        else $error("pair address");
    chk_word_dest: assert property (take && instr.opcode == 8'hC4
        |-> ##2 rf_req.wr_en && rf_req.wr_addr == $past(instr.dst, 2))
        else $error("word destination");
    chk_ind_word: assert property (take && instr.opcode == 8'hC5
        |-> ##3 rf_req.wr_en && rf_req.wr_addr == $past(instr.dst, 3))
        else $error("indirect word");
    chk_bad_code: assert property (take && !(instr.opcode inside
        {8'hF2, 8'hF3, 8'hC4, 8'hC5, 8'hC6}) |=> illegal && !busy)
        else $error("illegal code");
endmodule : ldexec_checker
bind ldexec ldexec_checker chk (.clk(clk), .resetn(resetn), .instr(instr),
    .rf_rd_data(rf_rd_data), .rf_req(rf_req), .mem_req(mem_req),
    .busy(busy), .done(done), .illegal(illegal));

/* verif/rf_model.sv */
`timescale 1ns/1ps
module rf_model (
    input  wire logic                clk,
    input  wire ldexec_pkg::rf_req_t req,
    output logic [15:0]              rd_data
);
    logic [7:0] regs [256];
    // Read follows the caller's registered request; junk while idle
    assign rd_data = req.rd_en
                   ? {regs[req.rd_addr], regs[req.rd_addr + 8'h01]}
                   : 16'hA5A5;
    always @(posedge clk) begin
        if (req.wr_en) begin
            regs[req.wr_addr]         <= req.wr_data[15:8];
            regs[req.wr_addr + 8'h01] <= req.wr_data[7:0];
        end
    end
endmodule : rf_model

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
    logic                 clk;
    logic                 resetn;
    ldexec_pkg::instr_t   instr;
    logic [15:0]          rf_rd_data;
    ldexec_pkg::rf_req_t  rf_req;
    ldexec_pkg::mem_req_t mem_req;
    ldexec_pkg::mem_req_t seen;
    logic                 busy;
    logic                 done;
    logic                 illegal;
    int                   n_mismatch = 0;
    int                   n_checks = 0;
    int                   n_wr = 0;
    int                   cyc = 0;
    ldexec uut (.clk(clk), .resetn(resetn), .instr(instr),
        .rf_rd_data(rf_rd_data), .rf_req(rf_req), .mem_req(mem_req),
        .busy(busy), .done(done), .illegal(illegal));
    rf_model u_rf (.clk(clk), .req(rf_req), .rd_data(rf_rd_data));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk) begin
        cyc++;
        if (mem_req.wr_en === 1'b1) begin
            n_wr++;
            seen = mem_req;
        end
        if (cyc == 3000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task check(input logic [15:0] got, exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check
    task end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task run(input logic [7:0] op, d, s, im, input int cycles);
        int n;
        @(negedge clk);
        instr = '{1'b1, op, d, s, im};
        @(negedge clk);
        instr.valid = 1'b0;
        check(16'(busy), 16'h0001, "busy");
        n = 1;
        while (done !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check(16'(n), 16'(cycles), "cycle count");
    endtask : run
    task s_store(input logic [7:0] op, d, input logic [15:0] p, exp);
        logic [7:0] a;
        a = {d[7:1], 1'b0};
        {u_rf.regs[a], u_rf.regs[a + 8'h01]} = p;
        u_rf.regs[8'h00] = 8'h77;
        n_wr = 0;
        run(op, d, 8'h00, 8'h00, 14);
        check(16'(n_wr), 16'h0001, "write count");
        check(seen.addr, exp, "address");
        check(16'(seen.data), 16'h0077, "data");
        check(16'(seen.prog_space), 16'(!d[0]), "space");
        check({u_rf.regs[a], u_rf.regs[a + 8'h01]}, exp, "pointer");
        check(16'(u_rf.regs[8'h00]), 16'h0077, "source");
    endtask : s_store
    task s_word();
        {u_rf.regs[8'h04], u_rf.regs[8'h05]} = 16'h061C;
        run(8'hC4, 8'h06, 8'h04, 8'h00, 8);
        check({u_rf.regs[8'h06], u_rf.regs[8'h07]}, 16'h061C, "pair");
        check({u_rf.regs[8'h04], u_rf.regs[8'h05]}, 16'h061C, "src");
        run(8'hC6, 8'h02, 8'h0F, 8'hED, 8);
        check({u_rf.regs[8'h02], u_rf.regs[8'h03]}, 16'h0FED, "imm");
        u_rf.regs[8'h09] = 8'h0A;
        {u_rf.regs[8'h0A], u_rf.regs[8'h0B]} = 16'h030F;
        run(8'hC5, 8'h04, 8'h09, 8'h00, 8);
        check({u_rf.regs[8'h04], u_rf.regs[8'h05]}, 16'h030F, "ind");
        check(16'(u_rf.regs[8'h09]), 16'h000A, "ind src");
    endtask : s_word
    task s_illegal();
        @(negedge clk);
        instr = '{1'b1, 8'h00, 8'h00, 8'h00, 8'h00};
        @(negedge clk);
        instr.valid = 1'b0;
        check(16'(illegal), 16'h0001, "illegal");
        check(16'(busy), 16'h0000, "not taken");
        repeat (20) begin
            @(negedge clk);
            check(16'(illegal | done), 16'h0000, "quiet");
        end
    endtask : s_illegal
    initial begin
        resetn = 1'b0;
        instr  = '0;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        s_store(8'hF2, 8'h06, 16'h3000, 16'h2FFF);
        s_store(8'hF2, 8'h07, 16'h3000, 16'h2FFF);
        s_store(8'hF3, 8'h06, 16'h21FF, 16'h2200);
        s_store(8'hF3, 8'h07, 16'hFFFF, 16'h0000);
        s_word();
        s_illegal();
        end_sim();
    end
endmodule : tb
